// File: verilog/tps_sram.sv
//------------------------------------------------------------
// Two-port 256x9 memory block, ports sampled on the core clock
//------------------------------------------------------------
module tps_sram
    import tps_pkg::*;
(
    // Core clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    // Fabric pins, asynchronous to clk
    input  wire tps_pkg::tps_pins_t         pins,
    // Read side results
    output logic [tps_pkg::DATA_W-1:0]      read_data,
    output logic                            read_parity_error,
    output logic                            read_data_unknown,
    // Write side result
    output logic                            write_parity_error
);
    import tps_pkg::*;

    //------------------------------------------------------------
    // Pin synchronisers
    //------------------------------------------------------------
    tps_pins_t                  meta_reg;
    tps_pins_t                  sync_reg;
    tps_pins_t                  prev_reg;

    // Two flops before any logic; prev only for edge detection
    always_ff @(posedge clk)
    begin
        meta_reg <= pins;
        sync_reg <= meta_reg;
        prev_reg <= sync_reg;
    end

    //------------------------------------------------------------
    // Storage and read path state
    //------------------------------------------------------------
    logic [DATA_W-1:0]          mem_reg [DEPTH];
    logic [DATA_W-1:0]          data1_reg;
    logic [DATA_W-1:0]          data1_next;
    logic [DATA_W-1:0]          pipe_reg;
    logic                       unk1_reg;
    logic                       unk1_next;
    logic                       unk_pipe_reg;
    logic [CNT_W-1:0]           hold_reg;
    logic [CNT_W-1:0]           hold_next;
    logic [ADDR_W-1:0]          held_addr_reg;
    logic                       wpe_reg;

    //------------------------------------------------------------
    // Edge and mode decode
    //------------------------------------------------------------
    wire logic wclk_rise   = sync_reg.write_port_clock & ~prev_reg.write_port_clock;
    wire logic rclk_rise   = sync_reg.read_port_clock & ~prev_reg.read_port_clock;
    wire logic wstb_fall   = ~sync_reg.write_strobe_n & prev_reg.write_strobe_n;
    wire logic mode_pipe   = sync_reg.read_mode == RD_PIPE;
    wire logic mode_async  = sync_reg.read_mode == RD_ASYNC;
    wire logic mode_sync   = (sync_reg.read_mode == RD_TRANSP) | mode_pipe;
    wire logic par_gen     = sync_reg.parity_generate_enable;

    // Selects and strobes are active low
    wire logic wr_sel      = ~sync_reg.write_select_n;
    wire logic rd_sel      = ~sync_reg.read_select_n & ~sync_reg.read_strobe_n;

    // Clocked write needs pulse and select low; strobe write fires on fall
    wire logic wr_sync_fire  = ~sync_reg.write_async & wclk_rise
                               & ~sync_reg.write_pulse_n & wr_sel;
    wire logic wr_async_fire = sync_reg.write_async & wstb_fall & wr_sel;
    wire logic wr_fire       = wr_sync_fire | wr_async_fire;
    wire logic rd_fire       = mode_sync & rclk_rise & rd_sel;
    wire logic rd_follow     = mode_async & rd_sel;

    //------------------------------------------------------------
    // Write word with optional generated parity
    //------------------------------------------------------------
    logic               wr_gen_bit;
    logic               wr_par_err;
    logic               rd_par_err;

    tps_parity u_wr_parity (
        .word    (sync_reg.write_data),
        .odd     (sync_reg.odd_parity_select),
        .gen_bit (wr_gen_bit),
        .error   (wr_par_err)
    );

    // Bit 8 replaced by generated parity when enabled
    wire logic [DATA_W-1:0] wr_word = par_gen
        ? {wr_gen_bit, sync_reg.write_data[PAR_BIT-1:0]}
        : sync_reg.write_data;

    //------------------------------------------------------------
    // Read word with same-word forwarding
    //------------------------------------------------------------
    // Setup is negative, so a write in the read's own cycle counts as first
    wire logic              same_word = wr_fire & (sync_reg.write_addr == sync_reg.read_addr);
    wire logic [DATA_W-1:0] rd_word   = same_word ? wr_word
                                                  : mem_reg[sync_reg.read_addr];
    // Write landing inside the hold window of the last read edge
    wire logic              late_hit  = wr_fire & ~rd_fire & (hold_reg != CNT_ZERO)
                                        & (sync_reg.write_addr == held_addr_reg);

    //------------------------------------------------------------
    // Storage write, no reset since contents are not cleared
    //------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (wr_fire)
            mem_reg[sync_reg.write_addr] <= wr_word;
    end

    //------------------------------------------------------------
    // Read stage next values
    //------------------------------------------------------------
    // Late write past the hold window leaves the captured old word alone
    always_comb
    begin
        data1_next = data1_reg;
        unk1_next  = unk1_reg;
        hold_next  = (hold_reg != CNT_ZERO) ? hold_reg - 3'h1 : CNT_ZERO;
        if (rd_fire | rd_follow)
        begin
            data1_next = rd_word;
            unk1_next  = 1'b0;
            hold_next  = rd_fire ? CNT_W'(HOLD_CYC) : CNT_ZERO;
        end
        else if (late_hit)
        begin
            unk1_next  = 1'b1;
        end
    end

    //------------------------------------------------------------
    // Read stage and pipeline registers
    //------------------------------------------------------------
    // Pipeline stage moves on each read clock rise: same outcome, one edge later
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            data1_reg     <= DATA_RST;
            unk1_reg      <= 1'b0;
            hold_reg      <= CNT_ZERO;
            held_addr_reg <= '0;
            pipe_reg      <= DATA_RST;
            unk_pipe_reg  <= 1'b0;
            wpe_reg       <= 1'b0;
        end
        else
        begin
            data1_reg     <= data1_next;
            unk1_reg      <= unk1_next;
            hold_reg      <= hold_next;
            if (rd_fire)
                held_addr_reg <= sync_reg.read_addr;
            if (mode_pipe & rclk_rise)
            begin
                pipe_reg     <= data1_reg;
                unk_pipe_reg <= unk1_reg;
            end
            // Flag forced quiet while generating, its value has no meaning
            wpe_reg       <= wr_par_err & ~par_gen;
        end
    end

    //------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------
    assign read_data          = mode_pipe ? pipe_reg : data1_reg;
    assign read_data_unknown  = mode_pipe ? unk_pipe_reg : unk1_reg;
    assign write_parity_error = wpe_reg;

    tps_parity u_rd_parity (
        .word    (read_data),
        .odd     (sync_reg.odd_parity_select),
        .gen_bit (),
        .error   (rd_par_err)
    );

    assign read_parity_error = rd_par_err;

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_fwd_same_word: assert property (rd_fire && same_word |=> data1_reg == $past(wr_word))
        else $error("same word read missed forwarded write data");
    a_write_first_new: assert property (rd_fire && wr_sync_fire
        && sync_reg.write_addr == sync_reg.read_addr |=> data1_reg == $past(wr_word) && !unk1_reg)
        else $error("write before read did not give new data");
    a_late_write_old: assert property ((rd_fire && !same_word) ##1 !wr_fire && !rd_fire
        ##1 (wr_fire && !rd_fire && !rd_follow) |=> $stable(data1_reg) && !unk1_reg)
        else $error("write after hold window changed the read word");
    a_window_unknown: assert property (rd_fire ##1 (wr_fire && !rd_fire && !rd_follow
        && sync_reg.write_addr == $past(sync_reg.read_addr)) |=> unk1_reg && $stable(data1_reg))
        else $error("write inside window not flagged unknown");
    a_strobe_new: assert property (rd_fire && wr_async_fire && same_word |=> data1_reg == $past(wr_word))
        else $error("strobe write at read edge lost new data");
    a_strobe_late_old: assert property (rd_fire ##1 !rd_fire && !wr_fire
        ##1 (wr_async_fire && !rd_fire && !rd_follow) |=> $stable(data1_reg) && !unk1_reg)
        else $error("late strobe write changed old word");
    a_pipe_delay: assert property (mode_pipe && rclk_rise ##1 mode_pipe
        |-> pipe_reg == $past(data1_reg) && read_data == pipe_reg)
        else $error("pipelined output not one read edge behind");
    a_pipe_unk: assert property (mode_pipe && rclk_rise |=> unk_pipe_reg == $past(unk1_reg))
        else $error("pipelined unknown flag differs from transparent");
    a_async_follow: assert property (rd_follow && !wr_fire
        |=> data1_reg == $past(mem_reg[sync_reg.read_addr]))
        else $error("async read did not follow address");
    a_wpe_quiet: assert property (par_gen |=> !write_parity_error)
        else $error("write parity flag active while generating");
    a_par_stored: assert property (wr_fire && par_gen
        |=> (^mem_reg[$past(sync_reg.write_addr)]) == $past(sync_reg.odd_parity_select))
        else $error("generated parity has wrong polarity");
    a_unsel_nowrite: assert property (wclk_rise && !sync_reg.write_async
        && (sync_reg.write_pulse_n || !wr_sel)
        |=> mem_reg[$past(sync_reg.write_addr)] == $past(mem_reg[sync_reg.write_addr]))
        else $error("refused clocked write changed memory");

endmodule : tps_sram

// File: verilog/tps_pkg.sv
//------------------------------------------------------------
// Behaviour
// - Same-word read and write at once: write data goes straight to read data.
// - Clocked write at or before the read clock edge: read returns new data.
// - Write clock edge after the hold window: read returns previously stored word.
// - Write inside the collision window: read output flagged unknown.
// - Strobe write falling at or before read clock edge: read returns new data.
// - Write strobe falling after the hold window: read returns the old word.
// - Collision outcomes identical in transparent and pipelined output modes.
// - Read select and strobe held low: asynchronous read follows read address alone.
// - Write parity error meaningless while parity generation is enabled.
// - Bit 8 carries parity; odd select high means odd, flags active high.
// - Pipelined output changes after second read clock edge, one cycle later.
//------------------------------------------------------------
package tps_pkg;

    //------------------------------------------------------------
    // Geometry
    //------------------------------------------------------------
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 9;
    localparam int PAR_BIT   = 8;
    localparam int DEPTH     = 256;

    //------------------------------------------------------------
    // Timing, core clock 250 MHz
    //------------------------------------------------------------
    localparam real CLK_PERIOD_NS = 4.0;
    // Negative setup: a write in the same core cycle counts as earlier
    localparam real SETUP_NS      = -0.1;
    localparam real HOLD_NS       = 7.0;
    localparam int  HOLD_CYC_RAW  = int'($floor(HOLD_NS / CLK_PERIOD_NS));
    localparam int  HOLD_CYC      = (HOLD_CYC_RAW < 1) ? 1 : HOLD_CYC_RAW;
    localparam int  CNT_W         = 3;

    //------------------------------------------------------------
    // Read port modes, one-hot
    //------------------------------------------------------------
    typedef enum logic [2:0] {
        RD_TRANSP = 3'h1,
        RD_PIPE   = 3'h2,
        RD_ASYNC  = 3'h4
    } tps_rd_mode_t;

    localparam logic [DATA_W-1:0] DATA_RST = 9'h000;
    localparam logic [CNT_W-1:0]  CNT_ZERO = 3'h0;

    //------------------------------------------------------------
    // Pin bundle from the fabric
    //------------------------------------------------------------
    typedef struct packed {
        logic                write_port_clock;
        logic                read_port_clock;
        logic                write_pulse_n;
        logic                write_strobe_n;
        logic                write_select_n;
        logic                read_strobe_n;
        logic                read_select_n;
        logic [ADDR_W-1:0]   write_addr;
        logic [ADDR_W-1:0]   read_addr;
        logic [DATA_W-1:0]   write_data;
        tps_rd_mode_t        read_mode;
        logic                write_async;
        logic                parity_generate_enable;
        logic                odd_parity_select;
    } tps_pins_t;

    // Parity bit that makes the 8 data bits odd or even
    function automatic logic par_bit(input logic [PAR_BIT-1:0] d, input logic odd);
        par_bit = (^d) ^ odd;
    endfunction : par_bit

endpackage : tps_pkg

// File: verilog/tps_parity.sv
//------------------------------------------------------------
// Parity generate and check for one 9-bit word
//------------------------------------------------------------
module tps_parity
    import tps_pkg::*;
(
    // Word and polarity
    input  wire logic [tps_pkg::DATA_W-1:0] word,
    input  wire logic                       odd,
    // Results
    output logic                            gen_bit,
    output logic                            error
);
    // Error when total ones disagree with polarity
    assign gen_bit = par_bit(word[PAR_BIT-1:0], odd);
    assign error   = word[PAR_BIT] != gen_bit;
endmodule : tps_parity

// File: bench/tps_fabric.sv
//------------------------------------------------------------
// Fabric user logic driving both ports
//------------------------------------------------------------
module tps_fabric
(
    // Core clock
    input  wire logic          clk,
    // Pins into the block
    output tps_pkg::tps_pins_t pins
);
    timeunit 1ns;
    timeprecision 100ps;
    import tps_pkg::*;

    // Idle: selects and read strobe low keep both ports live
    initial
    begin
        pins = '0;
        pins.write_strobe_n = 1'b1;
        pins.read_mode = RD_TRANSP;
    end

    // Port modes and parity controls
    task automatic mode(input tps_rd_mode_t md, input logic wa, pg, po);
        @(posedge clk);
        pins.read_mode <= md;
        pins.write_async <= wa;
        pins.parity_generate_enable <= pg;
        pins.odd_parity_select <= po;
        repeat (3) @(posedge clk);
    endtask : mode

    // Address, data and write qualifiers, set ahead of the event
    task automatic setup(input logic [7:0] wa, ra, input logic [8:0] wd, input logic pn, sn);
        @(posedge clk);
        pins.write_addr <= wa;
        pins.read_addr <= ra;
        pins.write_data <= wd;
        pins.write_pulse_n <= pn;
        pins.write_select_n <= sn;
        repeat (2) @(posedge clk);
    endtask : setup

    // Write event: clock rise or strobe fall, by write mode
    task automatic wev(input logic v);
        if (pins.write_async)
            pins.write_strobe_n <= ~v;
        else
            pins.write_port_clock <= v;
    endtask : wev

    // Read port select and strobe, both active low
    task automatic rd_enable(input logic en);
        @(posedge clk);
        pins.read_select_n <= ~en;
        pins.read_strobe_n <= ~en;
        repeat (3) @(posedge clk);
    endtask : rd_enable

    // One access; gap 0 puts both edges on one signal edge
    task automatic access(input logic w, r, input int gap);
        @(posedge clk);
        pins.read_port_clock <= r;
        repeat (gap) @(posedge clk);
        if (w)
            wev(1'b1);
        repeat (4) @(posedge clk);
        pins.read_port_clock <= 1'b0;
        if (w)
        begin
            wev(1'b0);
            // Released lines show no stale value
            pins.write_data <= ~pins.write_data;
            pins.write_addr <= ~pins.write_addr;
        end
        repeat (6) @(posedge clk);
    endtask : access
endmodule : tps_fabric

// File: bench/tps_sram_tb.sv
//------------------------------------------------------------
// Self-checking bench for the two-port memory block
//------------------------------------------------------------
module tps_sram_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import tps_pkg::*;

    typedef struct {string name; logic k; logic [10:0] v;} tps_note_t;
    logic              clk;
    logic              reset_n;
    tps_pins_t         pins;
    logic [8:0]        read_data;
    logic              read_parity_error;
    logic              read_data_unknown;
    logic              write_parity_error;
    int                errors = 0;
    int                checked = 0;
    tps_note_t         q[$];
    event              chk_ev;
    logic [7:0]        a;
    logic [8:0]        old_d;
    logic [8:0]        new_d;
    int                gp;

    // Core clock, 4 ns
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    tps_fabric fab (.clk(clk), .pins(pins));
    tps_sram dut (.clk(clk), .reset_n(reset_n), .pins(pins), .read_data(read_data),
        .read_parity_error(read_parity_error), .read_data_unknown(read_data_unknown),
        .write_parity_error(write_parity_error));

    function automatic logic [8:0] rnd9();
        rnd9 = 9'($urandom);
    endfunction : rnd9

    // Parity error over all nine bits
    function automatic logic perr(input logic [8:0] w, input logic odd);
        perr = (^w) ^ odd;
    endfunction : perr

    task automatic check(input string n, input logic [10:0] e, input logic [10:0] s);
        checked++;
        if (s !== e)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : check

    // Note an expectation, then flag that the result has settled
    task automatic note(input string n, input logic k, input logic [10:0] v);
        q.push_back('{n, k, v});
        @(posedge clk);
        #1 -> chk_ev;
    endtask : note

    task automatic exp_rd(input string n, input logic u, input logic [8:0] d);
        note(n, 1'b0, {u, perr(d, pins.odd_parity_select), d});
    endtask : exp_rd

    task automatic wr(input logic [7:0] wa, input logic [8:0] wd);
        fab.setup(wa, pins.read_addr, wd, 1'b0, 1'b0);
        fab.access(1'b1, 1'b0, 0);
    endtask : wr

    task automatic final_report();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    // Monitor: oldest note against the outputs
    always @(chk_ev)
    begin : mon
        tps_note_t n;
        n = q.pop_front();
        check(n.name, n.v, n.k ? {10'h000, write_parity_error}
            : {read_data_unknown, read_parity_error, read_data});
    end

    // Watchdog, far beyond the expected run
    initial
    begin
        #80000;
        errors++;
        final_report();
    end

    // Main sequence
    initial
    begin
        reset_n = 1'b0;
        void'($urandom(65432));
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        // Collisions: both clocked read modes, both write modes, four gaps
        for (int m = 0; m < 4; m++)
        begin
            fab.mode(tps_rd_mode_t'(m[1] ? RD_PIPE : RD_TRANSP), m[0], 1'b0, 1'b0);
            a = 8'($urandom);
            for (int g = 0; g < 4; g++)
            begin
                gp = g;
                old_d = rnd9();
                new_d = rnd9();
                wr(a, old_d);
                fab.setup(a, a, new_d, 1'b0, 1'b0);
                fab.access(1'b1, 1'b1, gp);
                if (m[1])
                    fab.access(1'b0, 1'b1, 0);
                exp_rd("collision", gp == 1, gp == 0 ? new_d : old_d);
            end
            $display("test collision mode %0d done", m);
        end
        // Clocked writes with pulse or select high are ignored
        fab.mode(RD_TRANSP, 1'b0, 1'b0, 1'b0);
        for (int k = 0; k < 2; k++)
        begin
            old_d = rnd9();
            wr(a, old_d);
            fab.setup(a, a, rnd9(), k == 0, k == 1);
            fab.access(1'b1, 1'b0, 0);
            fab.access(1'b0, 1'b1, 0);
            exp_rd("refused write", 1'b0, old_d);
        end
        $display("test refused writes done");
        // Asynchronous read follows the address alone
        fab.mode(RD_ASYNC, 1'b0, 1'b0, 1'b0);
        for (int k = 0; k < 4; k++)
        begin
            a = 8'($urandom);
            new_d = rnd9();
            wr(a, new_d);
            fab.setup(pins.write_addr, a, pins.write_data, 1'b0, 1'b0);
            repeat (4) @(posedge clk);
            exp_rd("async read", 1'b0, new_d);
        end
        $display("test async read done");
        // Port deselected: the write lands but the held word stays out
        fab.rd_enable(1'b0);
        old_d = new_d;
        new_d = rnd9();
        wr(a, new_d);
        exp_rd("read held", 1'b0, old_d);
        fab.rd_enable(1'b1);
        exp_rd("read resumed", 1'b0, new_d);
        $display("test read strobe done");
        // Parity: both polarities, generation off and on
        for (int k = 0; k < 4; k++)
        begin
            fab.mode(RD_TRANSP, 1'b0, k[1], k[0]);
            a = 8'($urandom);
            new_d = rnd9();
            fab.setup(a, a, new_d, 1'b0, 1'b0);
            repeat (3) @(posedge clk);
            // While generating, the write flag is meaningless and left alone
            if (!k[1])
                note("write parity", 1'b1, {10'h000, perr(new_d, k[0])});
            fab.access(1'b1, 1'b0, 0);
            fab.access(1'b0, 1'b1, 0);
            exp_rd("parity", 1'b0, k[1] ? {(^new_d[7:0]) ^ k[0], new_d[7:0]} : new_d);
        end
        $display("test parity done");
        final_report();
    end
endmodule : tps_sram_tb
